// ---- common/slos_map.vh ----
`ifndef SLOS_MAP_VH
`define SLOS_MAP_VH

// Register addresses, 15 bits as carried by the SPI instruction word.
`define SLOS_ADDR_SOFT_RESET      15'h0000
`define SLOS_ADDR_DATAPATH_RESET  15'h0001
`define SLOS_ADDR_POWER_MODE      15'h0002
`define SLOS_ADDR_DECIMATION      15'h0201
`define SLOS_ADDR_OUTPUT_FORMAT   15'h0561
`define SLOS_ADDR_LANE_RATE_BAND  15'h056e
`define SLOS_ADDR_PLL_STATUS      15'h056f
`define SLOS_ADDR_LINK_CONTROL    15'h0571
`define SLOS_ADDR_TAIL_CONTROL    15'h0584
`define SLOS_ADDR_DEEMPHASIS      15'h05c4
`define SLOS_ADDR_PLL_CAL         15'h1222
`define SLOS_ADDR_STARTUP         15'h1228
`define SLOS_ADDR_LOCK_CLEAR      15'h1262

// Reset values.
`define SLOS_RST_POWER_MODE       8'h00
`define SLOS_RST_DECIMATION       8'h01
`define SLOS_RST_OUTPUT_FORMAT    8'h00
`define SLOS_RST_LANE_RATE_BAND   8'h10
`define SLOS_RST_LINK_CONTROL     8'h00
`define SLOS_RST_TAIL_CONTROL     8'h00
`define SLOS_RST_DEEMPHASIS       8'h00
`define SLOS_RST_PLL_CAL          8'h00
`define SLOS_RST_STARTUP          8'h0f
`define SLOS_RST_LOCK_CLEAR       8'h00

// Trigger values of the self-clearing reset registers.
`define SLOS_SOFT_RESET_CODE      8'h81
`define SLOS_DATAPATH_RESET_CODE  8'h02

// Field positions.
`define SLOS_BIT_PLL_LOCKED       7
`define SLOS_BIT_LOCK_LOST        3
`define SLOS_BIT_LINK_POWER_DOWN  0
`define SLOS_BIT_PLL_CAL_RESET    2
`define SLOS_BIT_STARTUP_RESET    6
`define SLOS_BIT_LOCK_CLEAR       3
`define SLOS_BIT_OFFSET_BINARY    0
`define SLOS_BIT_TAIL_PRBS        4
`define SLOS_BIT_DEEMPH_EN        0
`define SLOS_BAND_MSB             7
`define SLOS_BAND_LSB             4
`define SLOS_CS_MSB               1
`define SLOS_CS_LSB               0
`define SLOS_PWR_MSB              1
`define SLOS_PWR_LSB              0

// SPI framing: instruction bits, then data bits.
`define SLOS_SPI_INSTR_BITS       5'd16
`define SLOS_SPI_FRAME_BITS       5'd24

// Tail bit pseudorandom generator seed.
`define SLOS_PRBS_SEED            9'h1ff

`endif

// ---- rtl/slos_pack.v ----
`timescale 1ns/10ps
`default_nettype none
`include "slos_map.vh"

// Splits one converter word into two octets with tail or control bits.
module slos_pack #(
    parameter N = 14
) (
    // Clock and reset
    input  wire         clk,
    input  wire         srst,
    input  wire         dp_rst,
    // Configuration
    input  wire         offset_binary,
    input  wire         tail_prbs,
    input  wire [1:0]   cs,
    // Sample and control bits
    input  wire [N-1:0] sample,
    input  wire         sample_valid,
    input  wire [2:0]   ctrl_bits,
    // Octets
    output reg  [7:0]   octet0,
    output reg  [7:0]   octet1,
    output reg          octet_valid
);

    reg  [8:0]   prbs_reg;
    reg  [1:0]   tail;
    reg  [N-1:0] word;

    wire [N-1:0] fmt = offset_binary ? {~sample[N-1], sample[N-2:0]} : sample;
    wire [1:0]   fill = tail_prbs ? prbs_reg[8:7] : 2'b00;

    // Control bits go in MSB first; with three of them bit 0 takes the sample LSB.
    always @* begin
        word = fmt;
        tail = fill;
        case (cs)
            2'd1:    tail = {ctrl_bits[2], fill[0]};
            2'd2:    tail = ctrl_bits[2:1];
            2'd3: begin
                tail    = ctrl_bits[2:1];
                word[0] = ctrl_bits[0];
            end
            default: tail = fill;
        endcase
    end

    always @(posedge clk) begin
        if (srst || dp_rst) begin
            prbs_reg    <= `SLOS_PRBS_SEED;
            octet0      <= 8'h00;
            octet1      <= 8'h00;
            octet_valid <= 1'b0;
        end else begin
            octet_valid <= sample_valid;
            if (sample_valid) begin
                prbs_reg <= {prbs_reg[6:0], prbs_reg[8] ^ prbs_reg[4], prbs_reg[7] ^ prbs_reg[3]};
                octet0   <= word[N-1:N-8];
                octet1   <= {word[N-9:0], tail};
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/slos_spi.v ----
`timescale 1ns/10ps
`default_nettype none
`include "slos_map.vh"

// Mode 0 SPI slave: 16-bit instruction (read flag, 15-bit address), one data byte.
// The serial pins are sampled on clk, so sclk must stay below a quarter of clk.
module slos_spi (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Serial pins
    input  wire        spi_sclk,
    input  wire        spi_csb_n,
    input  wire        spi_sdi,
    output reg         spi_sdo,
    output reg         spi_sdo_oe,
    // Register side
    output reg  [14:0] addr,
    output reg  [7:0]  wdata,
    output reg         wr_stb,
    input  wire [7:0]  rdata
);

    reg        sclk_reg;
    reg [4:0]  cnt_reg;
    reg [15:0] shift_reg;
    reg [7:0]  tx_reg;
    reg        is_read_reg;

    wire rise = spi_sclk & ~sclk_reg;
    wire fall = ~spi_sclk & sclk_reg;

    always @(posedge clk) begin
        if (srst) begin
            sclk_reg    <= 1'b0;
            cnt_reg     <= 5'd0;
            shift_reg   <= 16'h0000;
            tx_reg      <= 8'h00;
            is_read_reg <= 1'b0;
            addr        <= 15'h0000;
            wdata       <= 8'h00;
            wr_stb      <= 1'b0;
            spi_sdo     <= 1'b0;
            spi_sdo_oe  <= 1'b0;
        end else begin
            sclk_reg <= spi_sclk;
            wr_stb   <= 1'b0;
            if (spi_csb_n) begin
                cnt_reg    <= 5'd0;
                spi_sdo_oe <= 1'b0;
            end else begin
                if (rise && cnt_reg != `SLOS_SPI_FRAME_BITS) begin
                    shift_reg <= {shift_reg[14:0], spi_sdi};
                    cnt_reg   <= cnt_reg + 5'd1;
                    if (cnt_reg == `SLOS_SPI_INSTR_BITS - 5'd1) begin
                        is_read_reg <= shift_reg[14];
                        addr        <= {shift_reg[13:0], spi_sdi};
                    end
                    if (cnt_reg == `SLOS_SPI_FRAME_BITS - 5'd1 && !is_read_reg) begin
                        wdata  <= {shift_reg[6:0], spi_sdi};
                        wr_stb <= 1'b1;
                    end
                end
                if (fall && is_read_reg && cnt_reg >= `SLOS_SPI_INSTR_BITS) begin
                    spi_sdo_oe <= (cnt_reg != `SLOS_SPI_FRAME_BITS);
                    if (cnt_reg == `SLOS_SPI_INSTR_BITS) begin
                        spi_sdo <= rdata[7];
                        tx_reg  <= {rdata[6:0], 1'b0};
                    end else begin
                        spi_sdo <= tx_reg[7];
                        tx_reg  <= {tx_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/slos_top.v ----
// What this block does
// - Serializer clock from internal PLL at lane rate.
// - Status bit 7 reads PLL lock, read-only.
// - Sticky lock-lost bit 3 set on lock loss.
// - Link restart, bit 0 one then zero, clears it.
// - All four lanes form one single link.
// - Octet one bits 13-6, octet two 5-0 plus tails.
// - Tail bits are zeros or pseudorandom, as configured.
// - Control bits replace tails MSB first per CS.
// - Twos complement after reset until format reprogrammed.
// - Serial outputs powered up after reset.
// - De-emphasis disabled by default; enable sparingly.
`timescale 1ns/10ps
`default_nettype none
`include "slos_map.vh"

module slos_top #(
    parameter N     = 14,
    parameter LANES = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             srst,
    // SPI pins
    input  wire             spi_sclk,
    input  wire             spi_csb_n,
    input  wire             spi_sdi,
    output wire             spi_sdo,
    output wire             spi_sdo_oe,
    // Power-down pin
    input  wire             power_down_pin,
    // Serializer PLL
    input  wire             pll_lock_raw,
    output reg              pll_enable_reg,
    output reg  [3:0]       pll_band_reg,
    output reg              pll_cal_reset_reg,
    output reg              startup_reset_reg,
    // Serial lane drivers
    output reg  [LANES-1:0] lane_enable_reg,
    output reg              deemph_enable_reg,
    // Sample path
    input  wire [N-1:0]     sample_data,
    input  wire             sample_valid,
    input  wire             overrange_in,
    input  wire             sysref_in,
    input  wire             fast_detect_in,
    output wire [7:0]       octet0,
    output wire [7:0]       octet1,
    output wire             octet_valid
);

    wire [14:0] bus_addr;
    wire [7:0]  bus_wdata;
    wire        bus_wr;
    reg  [7:0]  bus_rdata;

    reg  [7:0]  power_mode_reg;
    reg  [7:0]  decimation_reg;
    reg  [7:0]  output_format_reg;
    reg  [7:0]  lane_rate_reg;
    reg  [7:0]  link_control_reg;
    reg  [7:0]  tail_control_reg;
    reg  [7:0]  deemph_reg;
    reg  [7:0]  pll_cal_reg;
    reg  [7:0]  startup_reg;
    reg  [7:0]  lock_clear_reg;
    reg         soft_rst_reg;
    reg         dp_rst_reg;
    reg         lock_q_reg;
    reg         locked_reg;
    reg         lock_lost_flag_reg;
    reg         lock_lost_flag_next;

    function hit;
        input [14:0] a;
        input [14:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    slos_spi i_slos_spi (
        .clk        (clk),
        .srst       (srst),
        .spi_sclk   (spi_sclk),
        .spi_csb_n  (spi_csb_n),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .addr       (bus_addr),
        .wdata      (bus_wdata),
        .wr_stb     (bus_wr),
        .rdata      (bus_rdata)
    );

    wire link_up   = ~power_down_pin && power_mode_reg[`SLOS_PWR_MSB:`SLOS_PWR_LSB] == 2'b00 &&
                     ~link_control_reg[`SLOS_BIT_LINK_POWER_DOWN];
    wire cal_reset = pll_cal_reg[`SLOS_BIT_PLL_CAL_RESET];
    wire wr_link   = bus_wr && hit(bus_addr, `SLOS_ADDR_LINK_CONTROL);

    // A restart is the falling edge of the power-down bit, seen at the write itself.
    wire restart   = wr_link && link_control_reg[`SLOS_BIT_LINK_POWER_DOWN] &&
                     ~bus_wdata[`SLOS_BIT_LINK_POWER_DOWN];
    wire lock_drop = link_up && ~cal_reset && lock_q_reg && ~pll_lock_raw;

    // Configuration registers; a soft reset code restores every default.
    always @(posedge clk) begin
        if (srst || soft_rst_reg) begin
            power_mode_reg    <= `SLOS_RST_POWER_MODE;
            decimation_reg    <= `SLOS_RST_DECIMATION;
            output_format_reg <= `SLOS_RST_OUTPUT_FORMAT;
            lane_rate_reg     <= `SLOS_RST_LANE_RATE_BAND;
            link_control_reg  <= `SLOS_RST_LINK_CONTROL;
            tail_control_reg  <= `SLOS_RST_TAIL_CONTROL;
            deemph_reg        <= `SLOS_RST_DEEMPHASIS;
            pll_cal_reg       <= `SLOS_RST_PLL_CAL;
            startup_reg       <= `SLOS_RST_STARTUP;
            lock_clear_reg    <= `SLOS_RST_LOCK_CLEAR;
        end else if (bus_wr) begin
            if (hit(bus_addr, `SLOS_ADDR_POWER_MODE)) begin
                power_mode_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_DECIMATION)) begin
                decimation_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_OUTPUT_FORMAT)) begin
                output_format_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_LANE_RATE_BAND)) begin
                lane_rate_reg <= bus_wdata;
            end
            if (wr_link) begin
                link_control_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_TAIL_CONTROL)) begin
                tail_control_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_DEEMPHASIS)) begin
                deemph_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_PLL_CAL)) begin
                pll_cal_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_STARTUP)) begin
                startup_reg <= bus_wdata;
            end
            if (hit(bus_addr, `SLOS_ADDR_LOCK_CLEAR)) begin
                lock_clear_reg <= bus_wdata;
            end
        end
    end

    // Self-clearing reset triggers; both read back as zero.
    always @(posedge clk) begin
        if (srst) begin
            soft_rst_reg <= 1'b0;
            dp_rst_reg   <= 1'b0;
        end else begin
            soft_rst_reg <= bus_wr && hit(bus_addr, `SLOS_ADDR_SOFT_RESET) &&
                            bus_wdata == `SLOS_SOFT_RESET_CODE;
            dp_rst_reg   <= bus_wr && hit(bus_addr, `SLOS_ADDR_DATAPATH_RESET) &&
                            bus_wdata == `SLOS_DATAPATH_RESET_CODE;
        end
    end

    // A drop of lock that lands in the clearing cycle still sets the flag.
    always @* begin
        lock_lost_flag_next = lock_lost_flag_reg;
        if (restart || lock_clear_reg[`SLOS_BIT_LOCK_CLEAR]) begin
            lock_lost_flag_next = 1'b0;
        end
        if (lock_drop) begin
            lock_lost_flag_next = 1'b1;
        end
    end

    // Lock tracking and PLL / lane control, all registered onto the pins.
    always @(posedge clk) begin
        if (srst) begin
            lock_q_reg         <= 1'b0;
            locked_reg         <= 1'b0;
            lock_lost_flag_reg <= 1'b0;
            pll_enable_reg     <= 1'b0;
            pll_band_reg       <= 4'h0;
            pll_cal_reset_reg  <= 1'b0;
            startup_reset_reg  <= 1'b0;
            lane_enable_reg    <= {LANES{1'b0}};
            deemph_enable_reg  <= 1'b0;
        end else begin
            lock_q_reg         <= pll_lock_raw;
            locked_reg         <= link_up && ~cal_reset && pll_lock_raw;
            lock_lost_flag_reg <= lock_lost_flag_next;
            pll_enable_reg     <= link_up;
            pll_band_reg       <= lane_rate_reg[`SLOS_BAND_MSB:`SLOS_BAND_LSB];
            pll_cal_reset_reg  <= cal_reset;
            startup_reset_reg  <= startup_reg[`SLOS_BIT_STARTUP_RESET];
            lane_enable_reg    <= {LANES{link_up}};
            deemph_enable_reg  <= deemph_reg[`SLOS_BIT_DEEMPH_EN];
        end
    end

    // Read mux; unmapped addresses and trigger registers read as zero.
    always @* begin
        bus_rdata = 8'h00;
        case (bus_addr)
            `SLOS_ADDR_POWER_MODE:     bus_rdata = power_mode_reg;
            `SLOS_ADDR_DECIMATION:     bus_rdata = decimation_reg;
            `SLOS_ADDR_OUTPUT_FORMAT:  bus_rdata = output_format_reg;
            `SLOS_ADDR_LANE_RATE_BAND: bus_rdata = lane_rate_reg;
            `SLOS_ADDR_LINK_CONTROL:   bus_rdata = link_control_reg;
            `SLOS_ADDR_TAIL_CONTROL:   bus_rdata = tail_control_reg;
            `SLOS_ADDR_DEEMPHASIS:     bus_rdata = deemph_reg;
            `SLOS_ADDR_PLL_CAL:        bus_rdata = pll_cal_reg;
            `SLOS_ADDR_STARTUP:        bus_rdata = startup_reg;
            `SLOS_ADDR_LOCK_CLEAR:     bus_rdata = lock_clear_reg;
            `SLOS_ADDR_PLL_STATUS: begin
                bus_rdata[`SLOS_BIT_PLL_LOCKED] = locked_reg;
                bus_rdata[`SLOS_BIT_LOCK_LOST]  = lock_lost_flag_reg;
            end
            default:                   bus_rdata = 8'h00;
        endcase
    end

    slos_pack #(
        .N (N)
    ) i_slos_pack (
        .clk           (clk),
        .srst          (srst || soft_rst_reg),
        .dp_rst        (dp_rst_reg),
        .offset_binary (output_format_reg[`SLOS_BIT_OFFSET_BINARY]),
        .tail_prbs     (tail_control_reg[`SLOS_BIT_TAIL_PRBS]),
        .cs            (tail_control_reg[`SLOS_CS_MSB:`SLOS_CS_LSB]),
        .sample        (sample_data),
        .sample_valid  (sample_valid && link_up),
        .ctrl_bits     ({overrange_in, sysref_in, fast_detect_in}),
        .octet0        (octet0),
        .octet1        (octet1),
        .octet_valid   (octet_valid)
    );

endmodule

`default_nettype wire

// ---- sim/slos_pll_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// Serializer PLL stand-in: locks a fixed time after it may run, drops on command.
module slos_pll_model #(
    parameter int LOCK_DLY = 20
) (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic cal_reset,
    input  wire logic drop,
    output var logic  lock
);
    int cnt = 0;

    initial lock = 1'b0;
    always @(posedge clk) begin
        if (!run || cal_reset || drop) begin
            cnt  <= 0;
            lock <= 1'b0;
        end else if (cnt < LOCK_DLY) begin
            cnt <= cnt + 1;
        end else begin
            lock <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ---- sim/slos_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module slos_top_assertions #(
    parameter int N     = 14,
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             srst,
    // Pins seen by the checker
    input wire logic             spi_csb_n,
    input wire logic             spi_sdo_oe,
    input wire logic             power_down_pin,
    input wire logic             pll_enable_reg,
    input wire logic [3:0]       pll_band_reg,
    input wire logic [LANES-1:0] lane_enable_reg,
    input wire logic             deemph_enable_reg,
    input wire logic [N-1:0]     sample_data,
    input wire logic             sample_valid,
    input wire logic [7:0]       octet0,
    input wire logic [7:0]       octet1,
    input wire logic             octet_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_pll_run;
        $fell(srst) && !power_down_pin |=> pll_enable_reg;
    endproperty
    a_pll_run: assert property (p_pll_run) else $error("pll not running after reset");
    property p_lanes_up;
        $fell(srst) && !power_down_pin |=> lane_enable_reg == {LANES{1'b1}};
    endproperty
    a_lanes_up: assert property (p_lanes_up) else $error("lanes not powered after reset");
    property p_band_default;
        $fell(srst) |=> pll_band_reg == 4'h1;
    endproperty
    a_band_default: assert property (p_band_default) else $error("band default wrong");
    property p_deemph_off;
        $fell(srst) |=> !deemph_enable_reg;
    endproperty
    a_deemph_off: assert property (p_deemph_off) else $error("de-emphasis on after reset");
    property p_power_down;
        $rose(power_down_pin) |-> ##[1:3] (!pll_enable_reg && lane_enable_reg == '0);
    endproperty
    a_power_down: assert property (p_power_down) else $error("link stays up while pin high");
    property p_octet_valid;
        sample_valid && pll_enable_reg |=> octet_valid;
    endproperty
    a_octet_valid: assert property (p_octet_valid) else $error("accepted sample gave no octets");
    property p_octet_bits;
        octet_valid |-> octet0[6:0] == $past(sample_data[12:6]) && octet1[7:3] == $past(sample_data[5:1]);
    endproperty
    a_octet_bits: assert property (p_octet_bits) else $error("sample bits misplaced");
    property p_no_spurious;
        octet_valid |-> $past(sample_valid);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("octets without sample");
    property p_sdo_release;
        spi_csb_n [*2] |-> !spi_sdo_oe;
    endproperty
    a_sdo_release: assert property (p_sdo_release) else $error("sdo driven while deselected");

    c_octets: cover property (sample_valid ##1 octet_valid);
    c_read: cover property ($rose(spi_sdo_oe));
    c_pin_down: cover property ($rose(power_down_pin) ##3 !pll_enable_reg);
endmodule

bind slos_top slos_top_assertions #(.N(N), .LANES(LANES)) i_slos_top_assertions (
    .clk(clk), .srst(srst), .spi_csb_n(spi_csb_n), .spi_sdo_oe(spi_sdo_oe),
    .power_down_pin(power_down_pin), .pll_enable_reg(pll_enable_reg), .pll_band_reg(pll_band_reg),
    .lane_enable_reg(lane_enable_reg), .deemph_enable_reg(deemph_enable_reg),
    .sample_data(sample_data), .sample_valid(sample_valid), .octet0(octet0), .octet1(octet1),
    .octet_valid(octet_valid)
);

`default_nettype wire

// ---- sim/slos_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "slos_map.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t ns: got %h want %h", $time, (a), (e)); end end

module slos_top_tb;
    logic        clk = 1'b0, srst = 1'b1, sclk = 1'b0, csb_n = 1'b1, sdi = 1'b0, pdn = 1'b0, drop = 1'b0;
    logic [13:0] sample = 14'h0000;
    logic        sval = 1'b0, ovr = 1'b0, sysref = 1'b0, fd = 1'b0;
    wire         sdo, sdo_oe, lock_raw, pll_en, cal_rst, st_rst, deemph, ov;
    wire  [3:0]  band, lanes;
    wire  [7:0]  o0, o1;
    logic [7:0]  q, a, b, e1, tails;
    logic [13:0] w;
    int          n_mismatch = 0, checks = 0;
    int          lr;

    initial forever #5 clk = ~clk;

    slos_top #(.N(14), .LANES(4)) i_slos_top (
        .clk(clk), .srst(srst), .spi_sclk(sclk), .spi_csb_n(csb_n), .spi_sdi(sdi), .spi_sdo(sdo),
        .spi_sdo_oe(sdo_oe), .power_down_pin(pdn), .pll_lock_raw(lock_raw), .pll_enable_reg(pll_en),
        .pll_band_reg(band), .pll_cal_reset_reg(cal_rst), .startup_reset_reg(st_rst), .lane_enable_reg(lanes),
        .deemph_enable_reg(deemph), .sample_data(sample), .sample_valid(sval), .overrange_in(ovr),
        .sysref_in(sysref), .fast_detect_in(fd), .octet0(o0), .octet1(o1), .octet_valid(ov)
    );
    slos_pll_model #(.LOCK_DLY(20)) i_slos_pll_model (
        .clk(clk), .run(pll_en), .cal_reset(cal_rst), .drop(drop), .lock(lock_raw)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sclk runs at an eighth of clk, keeping well inside the sampling margin of the slave.
    task automatic spi(input logic rd, input logic [14:0] ad, input logic [7:0] wd, output logic [7:0] rq);
        logic [23:0] f;
        f = {rd, ad, wd};
        rq = 8'h00;
        tick(1);
        csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            sclk = 1'b0;
            tick(4);
            if (i < 8) rq[i] = sdo;
            if (rd && i < 8) `CHK(sdo_oe, 1'b1)
            sclk = 1'b1;
            tick(4);
        end
        sclk = 1'b0;
        tick(4);
        csb_n = 1'b1;
        tick(4);
    endtask

    task automatic wr(input logic [14:0] ad, input logic [7:0] d);
        logic [7:0] u;
        spi(1'b0, ad, d, u);
    endtask

    task automatic rdc(input logic [14:0] ad, input logic [7:0] e);
        spi(1'b1, ad, 8'h00, q);
        `CHK(q, e)
    endtask

    task automatic link_init();
        wr(`SLOS_ADDR_STARTUP, 8'h4f);
        wr(`SLOS_ADDR_STARTUP, 8'h0f);
        wr(`SLOS_ADDR_PLL_CAL, 8'h00);
        wr(`SLOS_ADDR_PLL_CAL, 8'h04);
        wr(`SLOS_ADDR_PLL_CAL, 8'h00);
        wr(`SLOS_ADDR_LOCK_CLEAR, 8'h08);
        wr(`SLOS_ADDR_LOCK_CLEAR, 8'h00);
    endtask

    task automatic smp(input logic [13:0] d, output logic [7:0] x, output logic [7:0] y);
        tick(1);
        sample = d;
        sval = 1'b1;
        tick(1);
        sval = 1'b0;
        `CHK(ov, 1'b1)
        x = o0;
        y = o1;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        summarize();
    end

    initial begin
        tick(3);
        srst = 1'b0;
        tick(2);
        `CHK({pll_en, lanes, band, deemph}, 10'b1_1111_0001_0)
        rdc(`SLOS_ADDR_LANE_RATE_BAND, 8'h10);
        rdc(`SLOS_ADDR_STARTUP, 8'h0f);
        rdc(`SLOS_ADDR_DECIMATION, 8'h01);
        rdc(`SLOS_ADDR_OUTPUT_FORMAT, 8'h00);
        rdc(`SLOS_ADDR_DEEMPHASIS, 8'h00);
        wr(15'h0123, 8'h5a);
        rdc(15'h0123, 8'h00);
        $display("test defaults done");

        wr(`SLOS_ADDR_STARTUP, 8'h4f);
        `CHK(st_rst, 1'b1)
        wr(`SLOS_ADDR_STARTUP, 8'h0f);
        `CHK(st_rst, 1'b0)
        wr(`SLOS_ADDR_PLL_CAL, 8'h00);
        `CHK(cal_rst, 1'b0)
        wr(`SLOS_ADDR_PLL_CAL, 8'h04);
        `CHK(cal_rst, 1'b1)
        spi(1'b1, `SLOS_ADDR_PLL_STATUS, 8'h00, q);
        `CHK(q[7], 1'b0)
        wr(`SLOS_ADDR_PLL_CAL, 8'h00);
        wr(`SLOS_ADDR_LOCK_CLEAR, 8'h08);
        wr(`SLOS_ADDR_LOCK_CLEAR, 8'h00);
        wr(`SLOS_ADDR_PLL_STATUS, 8'h00);
        spi(1'b1, `SLOS_ADDR_PLL_STATUS, 8'h00, q);
        `CHK({q[7], q[3]}, 2'b10)
        $display("test init done");

        drop = 1'b1;
        tick(3);
        drop = 1'b0;
        tick(30);
        spi(1'b1, `SLOS_ADDR_PLL_STATUS, 8'h00, q);
        `CHK({q[7], q[3]}, 2'b11)
        wr(`SLOS_ADDR_LINK_CONTROL, 8'h01);
        `CHK({pll_en, lanes}, 5'h00)
        wr(`SLOS_ADDR_LINK_CONTROL, 8'h00);
        tick(30);
        spi(1'b1, `SLOS_ADDR_PLL_STATUS, 8'h00, q);
        `CHK({q[7], q[3]}, 2'b10)
        pdn = 1'b1;
        tick(4);
        `CHK({pll_en, lanes}, 5'h00)
        pdn = 1'b0;
        tick(4);
        `CHK(lanes, 4'hf)
        wr(`SLOS_ADDR_POWER_MODE, 8'h01);
        `CHK(lanes, 4'h0)
        wr(`SLOS_ADDR_POWER_MODE, 8'h00);
        $display("test lock done");

        w = 14'h2a5b;
        ovr = 1'b1;
        sysref = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(`SLOS_ADDR_TAIL_CONTROL, 8'(c));
            smp(w, a, b);
            e1 = (c == 0) ? {w[5:0], 2'b00} : (c == 1) ? {w[5:0], ovr, 1'b0} :
                 (c == 2) ? {w[5:0], ovr, sysref} : {w[5:1], fd, ovr, sysref};
            `CHK({a, b}, {w[13:6], e1})
        end
        wr(`SLOS_ADDR_TAIL_CONTROL, 8'h00);
        smp(w, a, b);
        `CHK({a, b}, {w[13:6], w[5:0], 2'b00})
        wr(`SLOS_ADDR_OUTPUT_FORMAT, 8'h01);
        smp(w, a, b);
        `CHK(a, {~w[13], w[12:6]})
        wr(`SLOS_ADDR_TAIL_CONTROL, 8'h10);
        tails = 8'h00;
        for (int k = 0; k < 8; k++) begin
            smp(14'h0000, a, b);
            tails = tails | b;
        end
        `CHK(tails[7:2] == 6'h00 && tails[1:0] != 2'b00, 1'b1)
        $display("test packing done");

        wr(`SLOS_ADDR_LINK_CONTROL, 8'h01);
        wr(`SLOS_ADDR_LANE_RATE_BAND, 8'h30);
        `CHK(band, 4'h3)
        wr(`SLOS_ADDR_LANE_RATE_BAND, 8'h50);
        `CHK(band, 4'h5)
        wr(`SLOS_ADDR_LANE_RATE_BAND, 8'h00);
        `CHK(band, 4'h0)
        wr(`SLOS_ADDR_DECIMATION, 8'h02);
        rdc(`SLOS_ADDR_DECIMATION, 8'h02);
        // Two converters, 16-bit words, a 1000 MHz clock, decimation 2 and four lanes give Mbps.
        lr = 2 * 16 * 10 / 8 * (1000 / 2) / 4;
        `CHK(lr * 2 >= 3375 && lr <= 16000, 1'b1)
        wr(`SLOS_ADDR_LANE_RATE_BAND, (lr > 13500) ? 8'h30 : (lr >= 6750) ? 8'h00 : (lr >= 3375) ? 8'h10 : 8'h50);
        `CHK(band, 4'h1)
        wr(`SLOS_ADDR_LINK_CONTROL, 8'h00);
        link_init();
        spi(1'b1, `SLOS_ADDR_PLL_STATUS, 8'h00, q);
        `CHK({q[7], q[3]}, 2'b10)
        wr(`SLOS_ADDR_DEEMPHASIS, 8'h01);
        `CHK(deemph, 1'b1)
        wr(`SLOS_ADDR_SOFT_RESET, `SLOS_SOFT_RESET_CODE);
        `CHK({band, deemph}, 5'b0001_0)
        rdc(`SLOS_ADDR_OUTPUT_FORMAT, 8'h00);
        link_init();
        spi(1'b1, `SLOS_ADDR_PLL_STATUS, 8'h00, q);
        `CHK({q[7], q[3]}, 2'b10)
        $display("test band and soft reset done");
        summarize();
    end
endmodule

`default_nettype wire
